// >>> hw/lsoc_device.sv
// Configuration registers for link B extra lanes, sync word, gain boost and over-range.
// Assumes the controller holds each request until the one-cycle answer, on the same clock.
`timescale 1ns/10ps
`include "lsoc_cfg.svh"

// How it works
// - extra lane bits enable lane clocks
// - serializer bit adds serializers for lanes
// - host changes lanes only with link off
// - extra lanes follow mode and pattern
// - extra-only lanes ramp for pattern 0/5
// - channel power-down bit 1 silences link B lanes
// - serializer clocked only if lower lanes on
// - sync field picks CRC-12 or FEC
// - sync choice matters only for 64b/66b
// - command fields always sent as zero
// - host changes sync only with link off
// - gain bit doubles filter output
// - boost applies whenever the gain bit is set
// - I over threshold sets control bit 0
// - threshold is fraction of 256
// - Q over threshold sets control bit 1
module lsoc_device import lsoc_pkg::*; (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst_b,
	// Register port.
	lsoc_if.dev regs,
	// Link settings from the rest of the converter.
	input wire logic [4:0] link_mode_select,
	input wire logic mode_is_64b66b,
	input wire logic [7:0] mode_lane_mask,
	input wire logic [3:0] test_pattern_select,
	input wire logic [1:0] channel_power_down,
	// Down-converter samples.
	input wire logic sample_valid,
	input wire lsoc_sample_t sample_i,
	input wire lsoc_sample_t sample_q,
	// Link B lane controls.
	output logic [7:0] lane_clock_enable,
	output logic [7:0] serializer_enable,
	output logic [7:0] lane_octet_ramp,
	output logic [4:0] lane_mode,
	output logic [3:0] lane_test_pattern,
	// Sync word and command content.
	output logic sync_send_crc12,
	output logic sync_send_fec,
	output logic [`LSOC_CMD_W-1:0] command_field,
	// Output samples with over-range control bits.
	output logic out_valid,
	output lsoc_sample_t out_i,
	output lsoc_sample_t out_q,
	output logic out_ctrl_i,
	output logic out_ctrl_q
);

	// ****************************************
	// Functions
	// ****************************************

	// Marks each lane whose lower lanes are all active.
	function automatic logic [7:0] lower_all_on(input logic [7:0] active);
		logic [7:0] ok;
		ok = 8'h00;
		ok[0] = 1'b1;
		for (int n = 1; n < 8; n++) begin
			ok[n] = ok[n-1] & active[n-1];
		end
		return ok;
	endfunction

	// Doubles a sample and saturates at full scale.
	function automatic lsoc_sample_t double_sat(input lsoc_sample_t x);
		logic signed [`LSOC_SAMPLE_W:0] wide;
		wide = {x, 1'b0};
		if (wide[`LSOC_SAMPLE_W] != wide[`LSOC_SAMPLE_W-1]) begin
			return wide[`LSOC_SAMPLE_W] ? {1'b1, {(`LSOC_SAMPLE_W-1){1'b0}}}
				: {1'b0, {(`LSOC_SAMPLE_W-1){1'b1}}};
		end
		return wide[`LSOC_SAMPLE_W-1:0];
	endfunction

	// ****************************************
	// Registers
	// ****************************************
	lsoc_byte_t extra_lane_enable_link_b;
	lsoc_byte_t sync_word_select;
	lsoc_byte_t downconverter_gain_config;
	lsoc_byte_t overrange_threshold_i;
	lsoc_byte_t overrange_threshold_q;
	logic take;
	logic take_wr;

	// A request is taken once; the answer pulse blocks a second take.
	assign take = regs.req & ~regs.ack;
	assign take_wr = take & regs.write;

	// Register writes, all bits stored as read-write.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			extra_lane_enable_link_b <= `LSOC_RST_EXTRA_LANE_B;
			sync_word_select <= `LSOC_RST_SYNC_WORD;
			downconverter_gain_config <= `LSOC_RST_GAIN_CFG;
			overrange_threshold_i <= `LSOC_RST_OVR_THR_I;
			overrange_threshold_q <= `LSOC_RST_OVR_THR_Q;
		end else if (take_wr) begin
			unique case (regs.addr)
				`LSOC_OFS_EXTRA_LANE_B: extra_lane_enable_link_b <= regs.wdata;
				`LSOC_OFS_SYNC_WORD: sync_word_select <= regs.wdata;
				`LSOC_OFS_GAIN_CFG: downconverter_gain_config <= regs.wdata;
				`LSOC_OFS_OVR_THR_I: overrange_threshold_i <= regs.wdata;
				`LSOC_OFS_OVR_THR_Q: overrange_threshold_q <= regs.wdata;
				default: begin
				end
			endcase
		end
	end

	// Answer pulse and read data; unmapped addresses read as zero.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			regs.ack <= 1'b0;
			regs.rdata <= 8'h00;
		end else begin
			regs.ack <= take;
			if (take) begin
				unique case (regs.addr)
					`LSOC_OFS_EXTRA_LANE_B: regs.rdata <= extra_lane_enable_link_b;
					`LSOC_OFS_SYNC_WORD: regs.rdata <= sync_word_select;
					`LSOC_OFS_GAIN_CFG: regs.rdata <= downconverter_gain_config;
					`LSOC_OFS_OVR_THR_I: regs.rdata <= overrange_threshold_i;
					`LSOC_OFS_OVR_THR_Q: regs.rdata <= overrange_threshold_q;
					default: regs.rdata <= 8'h00;
				endcase
			end
		end
	end

	// ****************************************
	// Lane enables
	// ****************************************
	logic [7:0] extra_lanes;
	logic link_b_up;
	logic [7:0] next_clock_enable;
	logic [7:0] wanted_ser;
	logic [7:0] next_ser_enable;
	logic ramp_pattern;

	// Bit 0 of the field is the serializer bit, so lane B0 comes from the mode only.
	// extra lane clocks
	assign extra_lanes = {extra_lane_enable_link_b[7:1], 1'b0};
	assign link_b_up = regs.link_enable & ~channel_power_down[`LSOC_PD_LINK_B];
	assign next_clock_enable = (mode_lane_mask | extra_lanes) & {8{link_b_up}};
	assign wanted_ser = mode_lane_mask
		| (extra_lanes & {8{extra_lane_enable_link_b[`LSOC_BIT_EXTRA_SER]}});
	assign next_ser_enable = wanted_ser & next_clock_enable & lower_all_on(next_clock_enable);
	// ramp for pattern 0 or 5
	assign ramp_pattern = (test_pattern_select == `LSOC_TEST_OFF)
		| (test_pattern_select == `LSOC_TEST_RAMP_ALT);

	// Lane controls, registered so the lane logic sees clean levels.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			lane_clock_enable <= 8'h00;
			serializer_enable <= 8'h00;
			lane_octet_ramp <= 8'h00;
			lane_mode <= 5'h00;
			lane_test_pattern <= 4'h0;
		end else begin
			lane_clock_enable <= next_clock_enable;
			serializer_enable <= next_ser_enable;
			lane_octet_ramp <= next_clock_enable & extra_lanes & ~mode_lane_mask
				& {8{ramp_pattern}};
			lane_mode <= link_mode_select;
			lane_test_pattern <= test_pattern_select;
		end
	end

	// ****************************************
	// Sync word and command content
	// ****************************************

	// Reserved codes send neither; 8b/10b modes ignore the field.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			sync_send_crc12 <= 1'b0;
			sync_send_fec <= 1'b0;
			command_field <= '0;
		end else begin
			sync_send_crc12 <= mode_is_64b66b & (sync_word_select[1:0] == `LSOC_SYNC_CRC12);
			sync_send_fec <= mode_is_64b66b & (sync_word_select[1:0] == `LSOC_SYNC_FEC);
			command_field <= '0;
		end
	end

	// ****************************************
	// Gain and over-range
	// ****************************************
	lsoc_sample_t gained_i;
	lsoc_sample_t gained_q;
	logic over_i;
	logic over_q;

	assign gained_i = downconverter_gain_config[`LSOC_BIT_GAIN_BOOST] ? double_sat(sample_i)
		: sample_i;
	assign gained_q = downconverter_gain_config[`LSOC_BIT_GAIN_BOOST] ? double_sat(sample_q)
		: sample_q;

	// Comparator for the I component.
	lsoc_ovr_cmp cmp_i (
		.sample(gained_i),
		.threshold(overrange_threshold_i),
		.over(over_i)
	);

	// Comparator for the Q component.
	lsoc_ovr_cmp cmp_q (
		.sample(gained_q),
		.threshold(overrange_threshold_q),
		.over(over_q)
	);

	// Output samples carry their control bits in the same cycle.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			out_valid <= 1'b0;
			out_i <= '0;
			out_q <= '0;
			out_ctrl_i <= 1'b0;
			out_ctrl_q <= 1'b0;
		end else begin
			out_valid <= sample_valid;
			if (sample_valid) begin
				out_i <= gained_i;
				out_q <= gained_q;
				out_ctrl_i <= over_i;
				out_ctrl_q <= over_q;
			end
		end
	end

endmodule

// >>> hw/lsoc_cfg.svh
// Offsets, field positions, reset values and widths for the lane, sync and over-range block.
// Assumes it is included by bare name from every file that needs a number.
`ifndef LSOC_CFG_SVH
`define LSOC_CFG_SVH

// ****************************************
// Device register port
// ****************************************
`define LSOC_ADDR_W 10
`define LSOC_OFS_EXTRA_LANE_B 10'h20b
`define LSOC_OFS_SYNC_WORD 10'h20f
`define LSOC_OFS_GAIN_CFG 10'h210
`define LSOC_OFS_OVR_THR_I 10'h211
`define LSOC_OFS_OVR_THR_Q 10'h212
`define LSOC_RST_EXTRA_LANE_B 8'h00
`define LSOC_RST_SYNC_WORD 8'h00
`define LSOC_RST_GAIN_CFG 8'h00
`define LSOC_RST_OVR_THR_I 8'hf2
`define LSOC_RST_OVR_THR_Q 8'hab
`define LSOC_BIT_EXTRA_SER 0
`define LSOC_BIT_GAIN_BOOST 0
`define LSOC_PD_LINK_B 1
`define LSOC_SYNC_CRC12 2'h0
`define LSOC_SYNC_FEC 2'h2
`define LSOC_TEST_OFF 4'h0
`define LSOC_TEST_RAMP_ALT 4'h5
`define LSOC_TEST_RAMP 4'h4
`define LSOC_CMD_W 7
`define LSOC_SAMPLE_W 12
`define LSOC_SCALE_SHIFT 3

// ****************************************
// Controller APB registers
// ****************************************
`define LSOC_APB_CTRL 12'h000
`define LSOC_APB_CMD 12'h004
`define LSOC_APB_STATUS 12'h008
`define LSOC_APB_IRQ_STATUS 12'h00c
`define LSOC_APB_IRQ_MASK 12'h010
`define LSOC_CMD_WRITE_BIT 31
`define LSOC_IRQ_DONE 0
`define LSOC_IRQ_REFUSED 1
`define LSOC_IRQ_W 2

`endif

// >>> hw/lsoc_pkg.sv
// Types shared by both ends of the lane, sync and over-range configuration link.
// Assumes lsoc_cfg.svh is found on the include path.
`include "lsoc_cfg.svh"
package lsoc_pkg;

	// ****************************************
	// Types
	// ****************************************
	typedef logic [`LSOC_ADDR_W-1:0] lsoc_addr_t;
	typedef logic [7:0] lsoc_byte_t;
	typedef logic signed [`LSOC_SAMPLE_W-1:0] lsoc_sample_t;

	// Controller transfer states.
	typedef enum logic [1:0] {
		LSOC_IDLE = 2'b01,
		LSOC_BUSY = 2'b10
	} lsoc_state_e;

endpackage

// >>> hw/lsoc_if.sv
// Register port between the converter's configuration logic and its controller.
// Assumes both ends run on the same clock and reset.
`timescale 1ns/10ps
`include "lsoc_cfg.svh"
interface lsoc_if import lsoc_pkg::*; ();
	// Request from the controller, held until the answer.
	logic req;
	logic write;
	lsoc_addr_t addr;
	lsoc_byte_t wdata;
	// One-cycle answer from the device.
	logic ack;
	lsoc_byte_t rdata;
	// Link enable level owned by the controller.
	logic link_enable;

	modport dev (input req, write, addr, wdata, link_enable, output ack, rdata);
	modport host (output req, write, addr, wdata, link_enable, input ack, rdata);
endinterface

// >>> hw/lsoc_ovr_cmp.sv
// Over-range comparator for one down-converter output component.
// Assumes a signed full-scale sample and an 8-bit threshold of full scale over 256.
`timescale 1ns/10ps
`include "lsoc_cfg.svh"
module lsoc_ovr_cmp import lsoc_pkg::*; (
	// Sample and threshold.
	input wire lsoc_sample_t sample,
	input wire lsoc_byte_t threshold,
	// Comparison result.
	output logic over
);

	logic [`LSOC_SAMPLE_W-1:0] magnitude;
	logic [`LSOC_SAMPLE_W-`LSOC_SCALE_SHIFT-1:0] scaled;
	lsoc_byte_t level;

	always_comb begin
		magnitude = sample[`LSOC_SAMPLE_W-1] ? (`LSOC_SAMPLE_W)'(-sample) : sample;
		scaled = magnitude[`LSOC_SAMPLE_W-1:`LSOC_SCALE_SHIFT];
		// The most negative code scales to 256, which saturates to the top level.
		level = scaled[`LSOC_SAMPLE_W-`LSOC_SCALE_SHIFT-1] ? 8'hff : scaled[7:0];
		over = (level >= threshold);
	end

endmodule

// >>> hw/lsoc_host.sv
// Controller end: an APB slave whose commands become transfers on the register port.
// Assumes software polls status or waits for the interrupt before a new command.
`timescale 1ns/10ps
`include "lsoc_cfg.svh"
module lsoc_host import lsoc_pkg::*; (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst_b,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// Interrupt.
	output logic irq,
	// Register port.
	lsoc_if.host port
);

	lsoc_state_e state;
	lsoc_byte_t last_rdata;
	logic [`LSOC_IRQ_W-1:0] irq_status;
	logic [`LSOC_IRQ_W-1:0] irq_mask;
	logic apb_wr;
	logic apb_rd;
	logic cmd_go;
	logic locked_reg;
	logic broken_lanes;
	logic refuse;
	logic done_ev;
	logic [7:0] lanes_with_b0;

	// Access completes on the edge where pready is sampled high.
	assign apb_wr = psel & penable & pready & pwrite;
	assign apb_rd = psel & ~penable & ~pwrite;
	assign cmd_go = apb_wr & (paddr == `LSOC_APB_CMD) & (state == LSOC_IDLE);
	assign locked_reg = port.link_enable & ((pwdata[9:0] == `LSOC_OFS_EXTRA_LANE_B)
		| (pwdata[9:0] == `LSOC_OFS_SYNC_WORD));
	assign lanes_with_b0 = {pwdata[23:17], 1'b1};
	assign broken_lanes = (pwdata[9:0] == `LSOC_OFS_EXTRA_LANE_B)
		& pwdata[16 + `LSOC_BIT_EXTRA_SER]
		& ((lanes_with_b0 & (lanes_with_b0 + 8'h01)) != 8'h00);
	assign refuse = cmd_go & pwdata[`LSOC_CMD_WRITE_BIT] & (locked_reg | broken_lanes);
	assign done_ev = (state == LSOC_BUSY) & port.ack;

	// No wait state: pready rises in the access cycle.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & (paddr > `LSOC_APB_IRQ_MASK);
			if (apb_rd) begin
				unique case (paddr)
					`LSOC_APB_CTRL: prdata <= {31'h0000_0000, port.link_enable};
					`LSOC_APB_STATUS: prdata <= {16'h0000, last_rdata, 7'h00,
						state == LSOC_BUSY};
					`LSOC_APB_IRQ_STATUS: prdata <= {30'h0000_0000, irq_status};
					`LSOC_APB_IRQ_MASK: prdata <= {30'h0000_0000, irq_mask};
					default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Link enable and interrupt mask.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			port.link_enable <= 1'b0;
			irq_mask <= '0;
		end else if (apb_wr) begin
			if (paddr == `LSOC_APB_CTRL) begin
				port.link_enable <= pwdata[0];
			end
			if (paddr == `LSOC_APB_IRQ_MASK) begin
				irq_mask <= pwdata[`LSOC_IRQ_W-1:0];
			end
		end
	end

	// Sticky events; a new event wins over a write-one clear.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			irq_status <= '0;
			irq <= 1'b0;
		end else begin
			irq_status <= (irq_status & ~({`LSOC_IRQ_W{apb_wr & (paddr == `LSOC_APB_IRQ_STATUS)}}
				& pwdata[`LSOC_IRQ_W-1:0])) | {refuse, done_ev};
			irq <= |(irq_status & irq_mask);
		end
	end

	// Transfer engine: holds the request until the one-cycle answer.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state <= LSOC_IDLE;
			port.req <= 1'b0;
			port.write <= 1'b0;
			port.addr <= '0;
			port.wdata <= 8'h00;
			last_rdata <= 8'h00;
		end else begin
			unique case (state)
				LSOC_IDLE: begin
					if (cmd_go & ~refuse) begin
						state <= LSOC_BUSY;
						port.req <= 1'b1;
						port.write <= pwdata[`LSOC_CMD_WRITE_BIT];
						port.addr <= pwdata[9:0];
						port.wdata <= pwdata[23:16];
					end
				end
				LSOC_BUSY: begin
					if (port.ack) begin
						state <= LSOC_IDLE;
						port.req <= 1'b0;
						last_rdata <= port.rdata;
					end
				end
			endcase
		end
	end

endmodule

// >>> bench/lsoc_props.sv
// Concurrent checks on the register port that joins the controller and the device.
// Assumes one clock and an active-low asynchronous reset shared by both ends.
`timescale 1ns/10ps
`include "lsoc_cfg.svh"
module lsoc_props import lsoc_pkg::*; (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst_b,
	// Register port.
	input wire logic req,
	input wire logic write,
	input wire lsoc_addr_t addr,
	input wire lsoc_byte_t wdata,
	input wire logic ack,
	input wire lsoc_byte_t rdata,
	input wire logic link_enable
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);
	// ****************************************
	// Handshake and settings guard
	// ****************************************
	// A request is taken only on an edge where no answer stands.
	wire take = req && !ack;
	a_ack_after_take: assert property (take |=> ack) else $error("no answer after take");
	a_ack_one_cycle: assert property (ack |=> !ack) else $error("answer held too long");
	a_ack_needs_take: assert property (!take |=> !ack) else $error("answer without request");
	a_req_held: assert property (take |=> req && $stable(addr) && $stable(write) && $stable(wdata))
		else $error("request changed before answer");
	a_req_drops: assert property (ack |=> !req) else $error("request not dropped on answer");
	a_rdata_held: assert property (!ack |-> $stable(rdata)) else $error("read data moved");
	a_lane_cfg_off: assert property (req && write
		&& addr == `LSOC_OFS_EXTRA_LANE_B |-> !link_enable)
		else $error("lane setting written with link on");
	a_sync_cfg_off: assert property (req && write
		&& addr == `LSOC_OFS_SYNC_WORD |-> !link_enable)
		else $error("sync setting written with link on");
	// Main traffic kinds.
	c_write: cover property (take && write);
	c_read: cover property (take && !write);
	c_link_on: cover property ($rose(link_enable));
endmodule

// >>> bench/lsoc_tb_top.sv
// Self-checking bench: APB master on the controller, device settings and samples driven here.
// Assumes the controller answers APB without waits and runs one command at a time.
`timescale 1ns/10ps
`include "lsoc_cfg.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
	$display("MISMATCH %s exp %h got %h", nm, e, g); end end
module lsoc_tb_top import lsoc_pkg::*;;
	typedef struct packed {
		logic [7:0] x, m;
		logic [3:0] p;
		logic [1:0] d;
		logic [7:0] c, s, r;
	} lsoc_row_s;
	// Extra lanes, mode lanes, pattern, power-down, then clocks, serializers, ramp.
	lsoc_row_s rows [6] = '{'{8'h00, 8'h0d, 4'h0, 2'h0, 8'h0d, 8'h01, 8'h00},
		'{8'h06, 8'h01, 4'h0, 2'h0, 8'h07, 8'h01, 8'h06},
		'{8'h07, 8'h01, 4'h5, 2'h0, 8'h07, 8'h07, 8'h06},
		'{8'h07, 8'h01, 4'h4, 2'h0, 8'h07, 8'h07, 8'h00},
		'{8'hff, 8'h00, 4'h0, 2'h1, 8'hfe, 8'h00, 8'hfe},
		'{8'h07, 8'h01, 4'h5, 2'h2, 8'h00, 8'h00, 8'h00}};
	lsoc_addr_t ra [6] = '{10'h20b, 10'h20f, 10'h210, 10'h211, 10'h212, 10'h300};
	lsoc_byte_t rv [6] = '{8'h00, 8'h00, 8'h00, 8'hf2, 8'hab, 8'h00};
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [4:0] link_mode_select = 5'h0b, lane_mode;
	logic mode_is_64b66b = 1'b0, sample_valid = 1'b0;
	logic [7:0] mode_lane_mask = 8'h00, lane_clock_enable, serializer_enable, lane_octet_ramp;
	logic [3:0] test_pattern_select = 4'h0, lane_test_pattern;
	logic [1:0] channel_power_down = 2'h0;
	lsoc_sample_t sample_i = 12'h000, sample_q = 12'h000, out_i, out_q;
	logic sync_send_crc12, sync_send_fec, out_valid, out_ctrl_i, out_ctrl_q;
	logic [`LSOC_CMD_W-1:0] command_field;
	lsoc_byte_t res;
	int bad_count = 0, n_compared = 0, cyc = 0;
	lsoc_if bus ();
	lsoc_host lsoc_host_i (.clock, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
		.prdata, .pslverr, .irq, .port(bus.host));
	lsoc_device lsoc_device_i (.clock, .rst_b, .regs(bus.dev), .link_mode_select,
		.mode_is_64b66b, .mode_lane_mask, .test_pattern_select, .channel_power_down,
		.sample_valid, .sample_i, .sample_q, .lane_clock_enable, .serializer_enable,
		.lane_octet_ramp, .lane_mode, .lane_test_pattern, .sync_send_crc12, .sync_send_fec,
		.command_field, .out_valid, .out_i, .out_q, .out_ctrl_i, .out_ctrl_q);
	lsoc_props lsoc_props_i (.clock, .rst_b, .req(bus.req), .write(bus.write), .addr(bus.addr),
		.wdata(bus.wdata), .ack(bus.ack), .rdata(bus.rdata), .link_enable(bus.link_enable));
	// ****************************************
	// Clock, timeout and tasks
	// ****************************************
	// The clock toggles every half period of 12.5 ns.
	always #12.5 clock = ~clock;
	// A hang is cut short well after the expected few hundred cycles.
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// One APB transfer; the request stands until pready is seen high at an edge.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// A device register transfer through the command word, then a poll until idle.
	task automatic cmd(input logic w, input lsoc_addr_t a, input lsoc_byte_t d);
		apb(1'b1, `LSOC_APB_CMD, {w, 7'h00, d, 6'h00, a});
		for (int k = 0; k < 20; k++) begin
			apb(1'b0, `LSOC_APB_STATUS, 32'h0);
			if (rd[0] === 1'b0) break;
		end
		res = rd[15:8];
	endtask
	task automatic settle();
		repeat (3) @(posedge clock);
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (20) @(posedge clock);
		rst_b <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			cmd(1'b0, ra[i], 8'h00);
			`CHK("reset value", rv[i], res);
		end
		sample_valid <= 1'b1;
		sample_i <= 12'h790;
		sample_q <= 12'haa8;
		settle();
		`CHK("ctrl i at default", 1'b1, out_ctrl_i);
		`CHK("ctrl q at default", 1'b1, out_ctrl_q);
		`CHK("sample valid", 1'b1, out_valid);
		sample_i <= 12'h78f;
		sample_q <= 12'haa9;
		settle();
		`CHK("ctrl i below", 1'b0, out_ctrl_i);
		`CHK("ctrl q below", 1'b0, out_ctrl_q);
		cmd(1'b1, `LSOC_OFS_GAIN_CFG, 8'h01);
		sample_i <= 12'h3c8;
		settle();
		`CHK("boosted i", 12'h790, out_i);
		`CHK("boosted ctrl", 1'b1, out_ctrl_i);
		`CHK("boosted q saturates", 12'h800, out_q);
		cmd(1'b1, `LSOC_OFS_GAIN_CFG, 8'h00);
		cmd(1'b1, `LSOC_OFS_OVR_THR_I, 8'hff);
		cmd(1'b1, `LSOC_OFS_OVR_THR_Q, 8'h00);
		sample_i <= 12'h800;
		sample_q <= 12'h000;
		settle();
		`CHK("full scale ctrl", 1'b1, out_ctrl_i);
		`CHK("zero threshold", 1'b1, out_ctrl_q);
		cmd(1'b0, `LSOC_OFS_OVR_THR_Q, 8'h00);
		`CHK("threshold readback", 8'h00, res);
		apb(1'b0, 12'h014, 32'h0);
		`CHK("unmapped apb", 1'b1, pslverr);
		apb(1'b1, `LSOC_APB_IRQ_MASK, 32'h3);
		settle();
		`CHK("irq done", 1'b1, irq);
		apb(1'b1, `LSOC_APB_IRQ_STATUS, 32'h3);
		settle();
		`CHK("irq cleared", 1'b0, irq);
		foreach (rows[i]) begin
			apb(1'b1, `LSOC_APB_CTRL, 32'h0);
			cmd(1'b1, `LSOC_OFS_EXTRA_LANE_B, rows[i].x);
			mode_lane_mask <= rows[i].m;
			test_pattern_select <= rows[i].p;
			channel_power_down <= rows[i].d;
			apb(1'b1, `LSOC_APB_CTRL, 32'h1);
			settle();
			`CHK("lane clocks", rows[i].c, lane_clock_enable);
			`CHK("serializers", rows[i].s, serializer_enable);
			`CHK("octet ramp", rows[i].r, lane_octet_ramp);
			`CHK("lane pattern", rows[i].p, lane_test_pattern);
			`CHK("lane mode", 5'h0b, lane_mode);
		end
		apb(1'b1, `LSOC_APB_IRQ_STATUS, 32'h3);
		cmd(1'b1, `LSOC_OFS_EXTRA_LANE_B, 8'h00);
		apb(1'b0, `LSOC_APB_IRQ_STATUS, 32'h0);
		`CHK("refused write", 1'b1, rd[1]);
		cmd(1'b0, `LSOC_OFS_EXTRA_LANE_B, 8'h00);
		`CHK("lanes kept", 8'h07, res);
		// A sync change with the link still on is refused as well.
		apb(1'b1, `LSOC_APB_IRQ_STATUS, 32'h3);
		cmd(1'b1, `LSOC_OFS_SYNC_WORD, 8'h02);
		apb(1'b0, `LSOC_APB_IRQ_STATUS, 32'h0);
		`CHK("refused sync", 1'b1, rd[1]);
		cmd(1'b0, `LSOC_OFS_SYNC_WORD, 8'h00);
		`CHK("sync kept", 8'h00, res);
		apb(1'b1, `LSOC_APB_CTRL, 32'h0);
		for (int c = 0; c < 4; c++) for (int m = 0; m < 2; m++) begin
			cmd(1'b1, `LSOC_OFS_SYNC_WORD, 8'(c));
			mode_is_64b66b <= m[0];
			settle();
			`CHK("sync crc", 1'((c == 0) && (m == 1)), sync_send_crc12);
			`CHK("sync fec", 1'((c == 2) && (m == 1)), sync_send_fec);
			`CHK("command field", 7'h00, command_field);
		end
		// A lane set with a gap below a serialized lane is refused.
		apb(1'b1, `LSOC_APB_IRQ_STATUS, 32'h3);
		cmd(1'b1, `LSOC_OFS_EXTRA_LANE_B, 8'h0b);
		apb(1'b0, `LSOC_APB_IRQ_STATUS, 32'h0);
		`CHK("gap refused", 1'b1, rd[1]);
		cmd(1'b0, `LSOC_OFS_EXTRA_LANE_B, 8'h00);
		`CHK("gap lanes kept", 8'h07, res);
		// A reset in mid-run clears outputs and restores the thresholds.
		rst_b <= 1'b0;
		settle();
		`CHK("reset valid", 1'b0, out_valid);
		`CHK("reset irq", 1'b0, irq);
		rst_b <= 1'b1;
		cmd(1'b0, `LSOC_OFS_OVR_THR_I, 8'h00);
		`CHK("thr i after reset", 8'hf2, res);
		cmd(1'b0, `LSOC_OFS_OVR_THR_Q, 8'h00);
		`CHK("thr q after reset", 8'hab, res);
		give_verdict();
	end
endmodule
